//--- hdl/match_timer_consts.svh
// constants for the match-clear timer / event counter
// assumes: included by the timer package and the timer module
`ifndef MATCH_TIMER_CONSTS_SVH
`define MATCH_TIMER_CONSTS_SVH
`define MODE_STOP     2'h0
`define MODE_EDGE_CLR 2'h2
`define MODE_MATCH    2'h3
`define CKSEL_EVENT   2'h3
`define EDGE_RISE     2'h1
`define EDGE_BOTH     2'h3
`define TOC_OE_BIT    0
`define TOC_TOG0_BIT  1
`define TOC_TOG1_BIT  4
`define TOC_LVR_BIT   2
`define TOC_LVS_BIT   3
`define TOC_SET_RST   8'h00
`define PRM_SET_RST   8'h00
`define TMC_SET_RST   8'h00
`define PM_SET_RST    8'hff
`define CNT_ZERO      16'h0000
`define CR_RST        16'h0000
`define DIV_2_LOG     2
`define DIV_8_LOG     8
`define DIV4_LAST     2'h3
`define DIV256_LAST   8'hff
`define CKSEL_FCLK    2'h0
`define CKSEL_DIV4    2'h1
`define CKSEL_DIV256  2'h2
`define TMC_MODE_HI   3
`define TMC_MODE_LO   2
`define PRM_CKSEL_HI  1
`define PRM_CKSEL_LO  0
`define PRM_EDGE_HI   5
`define PRM_EDGE_LO   4
`define PM_TO_BIT     1
`define TOC_WMASK     8'h13
`define SYNC_STAGES   3
`endif

//--- hdl/match_timer_pkg.sv
// types for the match-clear timer / event counter
// assumes: nothing beyond the constants header
`include "match_timer_consts.svh"
package match_timer_pkg;
	typedef enum logic [1:0] {
		run_stopped,
		run_first,
		run_active
	} run_state_t;
endpackage : match_timer_pkg

//--- hdl/match_clear_timer_event_counter.sv
// 16-bit match-clear interval timer, square-wave output and event counter
// assumes: registers written by the cpu through documented write strobes on clock
//
// Functional notes
// - mode 11 starts match-clear counting on count clock
// - compare zero match clears counter, raises irq zero
// - interval is compare value plus one counts
// - compare one match raises irq one, not masked in this module
// - compare zero match toggles output in square use
// - square frequency is half the match rate
// - clock select 11 counts event pin edges
// - later irq every compare plus one events
// - first irq after compare plus two events
// - event edge needs two consecutive equal samples
// - counter readable without disturbing counting
// - mode 00 stops and clears counter
// - edge select 01 rising, 11 both edges
// - direction bit 0 drives pin, 1 input
// - output control bit 1 enables toggle on compare zero match
// - output control bit 0 low holds output low
`include "match_timer_consts.svh"
module match_clear_timer_event_counter import match_timer_pkg::*; #(
	parameter int CNT_W = 16
) (
	input  wire logic             clock,        // peripheral clock, 50 MHz
	input  wire logic             srst,         // synchronous reset, active high
	input  wire logic             tmc_we,       // write strobe, mode control
	input  wire logic             toc_we,       // write strobe, output control
	input  wire logic             prm_we,       // write strobe, prescaler/edge select
	input  wire logic             cr0_we,       // write strobe, compare zero
	input  wire logic             cr1_we,       // write strobe, compare one
	input  wire logic             pm_we,        // write strobe, port direction
	input  wire logic [7:0]       wdata8,       // byte write data
	input  wire logic [CNT_W-1:0] wdata16,      // compare write data
	input  wire logic             event_input_pin, // external event pin
	output logic [CNT_W-1:0]      up_counter,   // counter value
	output logic [7:0]            tmc_rd,       // mode control readback
	output logic [7:0]            toc_rd,       // output control readback
	output logic [7:0]            prm_rd,       // prescaler readback
	output logic [7:0]            pm_rd,        // port direction readback
	output logic [CNT_W-1:0]      cr0_rd,       // compare zero readback
	output logic [CNT_W-1:0]      cr1_rd,       // compare one readback
	output logic                  match_irq_zero, // match zero pulse
	output logic                  match_irq_one,  // match one pulse
	output logic                  timer_output_pin, // timer output level on pin
	output logic                  timer_output_oe   // pin output enable
);
	initial begin
		if (CNT_W < 2 || CNT_W > 16)
			$error("CNT_W out of range");
	end

	// software-visible registers, then internal state
	logic [7:0]       timer_mode_control_reg;
	logic [7:0]       timer_output_control;
	logic [7:0]       prescaler_edge_select;
	logic [7:0]       port_direction_reg;
	logic [CNT_W-1:0] compare_reg_zero;
	logic [CNT_W-1:0] compare_reg_one;
	logic [7:0]                prediv_r;
	logic [`SYNC_STAGES-1:0]   ev_sync_r;
	logic             ev_level_r;
	logic             ev_armed_r;
	logic             to_level_r;
	run_state_t       run_r;
	// decoded fields and strobes
	logic [1:0]       op_mode;
	logic [1:0]       clock_sel;
	logic [1:0]       edge_sel;
	logic             running;
	logic             tick;
	logic             ev_edge;
	logic             ev_new;
	logic             match0;
	logic             match1;

	// edge polarity decode; the prohibited code falls back to falling edges
	function automatic logic edge_ok(input logic [1:0] sel, input logic old_l,
	                                 input logic new_l);
		case (sel)
			`EDGE_RISE: edge_ok = !old_l && new_l;
			`EDGE_BOTH: edge_ok = old_l != new_l;
			default:    edge_ok = old_l && !new_l;
		endcase
	endfunction : edge_ok

	assign op_mode   = timer_mode_control_reg[`TMC_MODE_HI:`TMC_MODE_LO];
	assign clock_sel = prescaler_edge_select[`PRM_CKSEL_HI:`PRM_CKSEL_LO];
	assign edge_sel  = prescaler_edge_select[`PRM_EDGE_HI:`PRM_EDGE_LO];
	assign running   = op_mode != `MODE_STOP;

	// mode control register; only the two mode bits steer the logic
	always_ff @(posedge clock) begin
		if (srst)
			timer_mode_control_reg <= `TMC_SET_RST;
		else if (tmc_we)
			timer_mode_control_reg <= wdata8;
	end

	// count clock and edge select; rewriting it while running is not guarded
	always_ff @(posedge clock) begin
		if (srst)
			prescaler_edge_select <= `PRM_SET_RST;
		else if (prm_we)
			prescaler_edge_select <= wdata8;
	end

	// port direction, every pin an input after reset
	always_ff @(posedge clock) begin
		if (srst)
			port_direction_reg <= `PM_SET_RST;
		else if (pm_we)
			port_direction_reg <= wdata8;
	end

	// compare zero; a zero value would match forever and is left to software
	always_ff @(posedge clock) begin
		if (srst)
			compare_reg_zero <= `CR_RST;
		else if (cr0_we)
			compare_reg_zero <= wdata16;
	end

	// compare one only feeds the second match pulse and its toggle
	always_ff @(posedge clock) begin
		if (srst)
			compare_reg_one <= `CR_RST;
		else if (cr1_we)
			compare_reg_one <= wdata16;
	end

	// output control keeps enable and toggle bits; level triggers read as zero
	always_ff @(posedge clock) begin
		if (srst)
			timer_output_control <= `TOC_SET_RST;
		else if (toc_we)
			timer_output_control <= wdata8 & `TOC_WMASK;
	end

	// event pin: three flops, a change counts when second and third agree
	always_ff @(posedge clock) begin
		if (srst)
			ev_sync_r[0] <= 1'b0;
		else
			ev_sync_r[0] <= event_input_pin;
	end

	for (genvar g = 1; g < `SYNC_STAGES; g++) begin : g_sync
		always_ff @(posedge clock) begin
			if (srst)
				ev_sync_r[g] <= 1'b0;
			else
				ev_sync_r[g] <= ev_sync_r[g-1];
		end
	end

	// settled level; a one-sample pulse never reaches it
	always_ff @(posedge clock) begin
		if (srst)
			ev_level_r <= 1'b0;
		else if (ev_sync_r[1] == ev_sync_r[2])
			ev_level_r <= ev_sync_r[2];
	end

	// qualified edge of the selected polarity, one clock wide
	assign ev_new  = (ev_sync_r[1] == ev_sync_r[2]) ? ev_sync_r[2] : ev_level_r;
	assign ev_edge = edge_ok(edge_sel, ev_level_r, ev_new) && ev_new != ev_level_r;

	// divider held at zero while stopped so every start is aligned
	always_ff @(posedge clock) begin
		if (srst || !running)
			prediv_r <= 8'h00;
		else
			prediv_r <= prediv_r + 8'h01;
	end

	// count clock tick, one peripheral clock wide
	always_comb begin
		case (clock_sel)
			`CKSEL_FCLK:   tick = running;
			`CKSEL_DIV4:   tick = running && (prediv_r[`DIV_2_LOG-1:0] == `DIV4_LAST);
			`CKSEL_DIV256: tick = running && (prediv_r == `DIV256_LAST);
			`CKSEL_EVENT:  tick = running && ev_edge && ev_armed_r;
			default:       tick = 1'b0;
		endcase
	end

	// first event after start only arms the counter, giving compare plus two
	always_ff @(posedge clock) begin
		if (srst || !running)
			ev_armed_r <= 1'b0;
		else if (clock_sel == `CKSEL_EVENT && ev_edge)
			ev_armed_r <= 1'b1;
	end

	// raw compare results, qualified by tick wherever they act
	assign match0 = (up_counter == compare_reg_zero);
	assign match1 = (up_counter == compare_reg_one);

	// run state and counter; reads take the output flops and never touch it
	// run_first is not entered: a start goes straight to active
	always_ff @(posedge clock) begin
		if (srst) begin
			run_r      <= run_stopped;
			up_counter <= `CNT_ZERO;
		end else begin
			case (run_r)
				run_stopped: begin
					up_counter <= `CNT_ZERO;
					if (op_mode == `MODE_MATCH)
						run_r <= run_active;
				end
				run_first, run_active: begin
					if (!running) begin
						run_r      <= run_stopped;
						up_counter <= `CNT_ZERO;
					end else if (tick) begin
						if (op_mode == `MODE_MATCH && match0)
							up_counter <= `CNT_ZERO;
						else
							up_counter <= up_counter + 1'b1;
					end
				end
				default: run_r <= run_stopped;
			endcase
		end
	end

	// match zero pulse, one per count tick on the matching value
	always_ff @(posedge clock) begin
		if (srst)
			match_irq_zero <= 1'b0;
		else
			match_irq_zero <= tick && run_r != run_stopped && match0;
	end

	// match one pulse; masking it is left to the interrupt controller
	always_ff @(posedge clock) begin
		if (srst)
			match_irq_one <= 1'b0;
		else
			match_irq_one <= tick && run_r != run_stopped && match1;
	end

	// timer output toggling on compare zero match with toggle bit 1 and on compare one match with toggle bit 4
	always_ff @(posedge clock) begin
		if (srst || !running)
			to_level_r <= 1'b0;
		else if (!timer_output_control[`TOC_OE_BIT])
			to_level_r <= 1'b0;
		else if (tick && match0 && timer_output_control[`TOC_TOG0_BIT])
			to_level_r <= !to_level_r;
		else if (tick && match1 && timer_output_control[`TOC_TOG1_BIT])
			to_level_r <= !to_level_r;
	end

	// pin level, registered so the pin never shows a decode glitch
	always_ff @(posedge clock) begin
		if (srst)
			timer_output_pin <= 1'b0;
		else
			timer_output_pin <= to_level_r;
	end

	// pin output enable: a cleared direction bit drives the pin
	always_ff @(posedge clock) begin
		if (srst)
			timer_output_oe <= 1'b0;
		else
			timer_output_oe <= !port_direction_reg[`PM_TO_BIT];
	end

	// register readback, one clock behind the registers
	always_ff @(posedge clock) begin
		if (srst) begin
			tmc_rd <= 8'h00;
			toc_rd <= 8'h00;
			prm_rd <= 8'h00;
			pm_rd  <= 8'h00;
			cr0_rd <= `CR_RST;
			cr1_rd <= `CR_RST;
		end else begin
			tmc_rd <= timer_mode_control_reg;
			toc_rd <= timer_output_control;
			prm_rd <= prescaler_edge_select;
			pm_rd  <= port_direction_reg;
			cr0_rd <= compare_reg_zero;
			cr1_rd <= compare_reg_one;
		end
	end
endmodule : match_clear_timer_event_counter

//--- sim/match_timer_assertions.sv
// port assertions for the match-clear timer
// assumes: bound to every timer instance, one clock domain
module match_timer_assertions #(
	parameter int CNT_W = 16
) (
	input wire logic             clock,            // clk
	input wire logic             srst,             // rst
	input wire logic [CNT_W-1:0] up_counter,       // cnt
	input wire logic [7:0]       tmc_rd,           // mode
	input wire logic [7:0]       toc_rd,           // out ctl
	input wire logic [7:0]       prm_rd,           // clk sel
	input wire logic [7:0]       pm_rd,            // dir
	input wire logic [CNT_W-1:0] cr0_rd,           // cmp 0
	input wire logic             match_irq_zero,   // irq 0
	input wire logic             match_irq_one,    // irq 1
	input wire logic             timer_output_pin, // out
	input wire logic             timer_output_oe   // oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	logic [CNT_W:0] gap_r;
	logic           seen_r;
	// cycles since last match, fclk interval runs only
	always_ff @(posedge clock) begin
		if (srst || tmc_rd[3:2] != 2'h3 || prm_rd[1:0] != 2'h0) begin
			seen_r <= 1'b0;
			gap_r  <= '0;
		end else if (match_irq_zero) begin
			seen_r <= 1'b1;
			gap_r  <= {{CNT_W{1'b0}}, 1'b1};
		end else begin
			gap_r <= gap_r + 1'b1;
		end
	end
	sequence s_stopped;
		(tmc_rd[3:2] == 2'h0) [*3];
	endsequence
	sequence s_square;
		toc_rd[1:0] == 2'h3 ##1 (toc_rd[1:0] == 2'h3 && match_irq_zero);
	endsequence
	property p_period;
		seen_r && match_irq_zero |-> gap_r == {1'b0, cr0_rd} + 1'b1;
	endproperty
	property p_bound;
		tmc_rd[3:2] == 2'h3 && $stable(cr0_rd) |-> up_counter <= cr0_rd;
	endproperty
	property p_pulse0;
		match_irq_zero |=> !match_irq_zero;
	endproperty
	property p_pulse1;
		match_irq_one |=> !match_irq_one;
	endproperty
	property p_toggle;
		s_square |=> timer_output_pin != $past(timer_output_pin);
	endproperty
	property p_low;
		!toc_rd[0] ##1 !toc_rd[0] |-> !timer_output_pin;
	endproperty
	property p_oe_on;
		pm_rd != 8'h00 && !pm_rd[1] ##1 !pm_rd[1] |-> timer_output_oe;
	endproperty
	property p_oe_off;
		pm_rd[1] ##1 pm_rd[1] |-> !timer_output_oe;
	endproperty
	property p_stop;
		s_stopped |-> up_counter == '0 && !match_irq_zero;
	endproperty
	a_period: assert property (p_period) else $error("bad match period");
	a_bound: assert property (p_bound) else $error("count passed compare");
	a_pulse0: assert property (p_pulse0) else $error("irq zero too long");
	a_pulse1: assert property (p_pulse1) else $error("irq one too long");
	a_toggle: assert property (p_toggle) else $error("no toggle on match");
	a_low: assert property (p_low) else $error("disabled output high");
	a_oe_on: assert property (p_oe_on) else $error("pin not driven");
	a_oe_off: assert property (p_oe_off) else $error("input pin driven");
	a_stop: assert property (p_stop) else $error("runs while stopped");
endmodule : match_timer_assertions
bind match_clear_timer_event_counter match_timer_assertions #(.CNT_W(CNT_W)) u_chk (.clock,
	.srst, .up_counter, .tmc_rd, .toc_rd, .prm_rd, .pm_rd, .cr0_rd, .match_irq_zero,
	.match_irq_one, .timer_output_pin, .timer_output_oe);

//--- sim/event_source.sv
// event source model on the timer event pin
// assumes: clock is the timer peripheral clock
module event_source (
	input wire logic clock,          // clk
	output logic     event_input_pin // level
);
	timeunit 1ns;
	timeprecision 1ps;
	initial event_input_pin = 1'b0;
	task automatic flip(input int n);
		@(posedge clock);
		event_input_pin <= ~event_input_pin;
		repeat (n) @(posedge clock);
	endtask : flip
	task automatic events(input int n, input bit both);
		for (int i = 0; i < n * (both ? 1 : 2); i++)
			flip(4);
	endtask : events
	task automatic glitch;
		flip(0);
		flip(5);
	endtask : glitch
endmodule : event_source

//--- sim/match_clear_timer_event_counter_tb.sv
// self-checking bench for the match-clear timer
// assumes: checker bound in its own file, event source model beside
module match_clear_timer_event_counter_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic [5:0]  we = '0;
	logic [7:0]  wdata8 = '0;
	logic [15:0] wdata16 = '0;
	logic        event_input_pin, match_irq_zero, match_irq_one, timer_output_pin, timer_output_oe;
	logic [15:0] up_counter, cr0_rd, cr1_rd;
	logic [7:0]  tmc_rd, toc_rd, prm_rd, pm_rd;
	int          n_fail = 0, check_count = 0, seed = 28814, cyc = 0, n_irq1 = 0, m;
	int          irq_q[$];
	always #10 clock = ~clock;
	match_clear_timer_event_counter u_dut (.clock, .srst, .tmc_we(we[0]), .toc_we(we[1]),
		.prm_we(we[2]), .cr0_we(we[3]), .cr1_we(we[4]), .pm_we(we[5]), .wdata8, .wdata16,
		.event_input_pin, .up_counter, .tmc_rd, .toc_rd, .prm_rd, .pm_rd, .cr0_rd, .cr1_rd,
		.match_irq_zero, .match_irq_one, .timer_output_pin, .timer_output_oe);
	event_source u_src (.clock, .event_input_pin);
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (match_irq_zero === 1'b1)
			irq_q.push_back(cyc);
		if (match_irq_one === 1'b1)
			n_irq1 <= n_irq1 + 1;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input int sel, input logic [15:0] d);
		@(posedge clock);
		we[sel] <= 1'b1;
		wdata8  <= d[7:0];
		wdata16 <= d;
		@(posedge clock);
		we[sel] <= 1'b0;
	endtask : wr
	task automatic complete_run;
		if (n_fail == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	task automatic ev_run(input logic [7:0] prm, input bit both);
		wr(0, 16'h0000);
		wr(2, {8'h00, prm});
		wr(3, 16'(m));
		irq_q = {};
		wr(0, 16'h000c);
		u_src.glitch();
		for (int n = 0; n < 3; n++) begin
			u_src.events(n == 1 ? 1 : m + 1, both);
			repeat (10) @(posedge clock);
			chk(irq_q.size(), n);
		end
	endtask : ev_run
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		complete_run();
	end
	initial begin
		repeat (10) @(posedge clock);
		srst <= 1'b0;
		repeat (2) @(posedge clock);
		chk(pm_rd, 8'hff);
		chk(toc_rd, 8'h00);
		wr(1, 16'h00ff);
		repeat (2) @(posedge clock);
		chk(toc_rd, 8'h13);
		m = 3 + ($random(seed) & 15);
		wr(5, 16'h00fd);
		wr(1, 16'h0003);
		wr(2, 16'h0000);
		wr(3, 16'(m));
		wr(4, 16'h0001);
		irq_q = {};
		wr(0, 16'h000c);
		for (int i = 0; i < 2000 && irq_q.size() < 5; i++)
			@(posedge clock);
		repeat (2) @(posedge clock);
		chk(timer_output_pin, irq_q.size() % 2);
		chk(timer_output_oe, 1'b1);
		for (int k = 1; k < 5; k++)
			chk(irq_q[k] - irq_q[k-1], m + 1);
		chk(n_irq1 >= irq_q.size(), 1'b1);
		wr(0, 16'h0000);
		repeat (3) @(posedge clock);
		chk(up_counter, 16'h0000);
		wr(1, 16'h0001);
		m = 2 + 2 * ($random(seed) & 3);
		ev_run(8'h13, 1'b0);
		ev_run(8'h33, 1'b1);
		chk(timer_output_pin, 1'b0);
		complete_run();
	end
endmodule : match_clear_timer_event_counter_tb
